// ==== verilog/supply_supervisor_defines.vh ====
// Constants for the supply supervisor, reset and sleep controller
// Behaviour
// - Volatile mode: release processor pins below battery
// - Power-down interrupt pulse low at least 200 us
// - Volatile mode: interrupt floats below battery voltage
// - Volatile mode: resets active at supply trip
// - Volatile mode: resets held for reset period
// - Power-up: block low input until trip point
// - Interrupt ends on timeout or input recovery
// - Backed mode: silence after pulse until recovery
// - Backed mode: no reset at supply trip
// - Backed mode: pulse then hold interrupt high
// - Backed mode: reset starts at battery level
// - Backed mode: low input pulse during reset cancels reset
// - Strobe while input low gives new pulse
// - Backed mode: input recovery without trip gives watchdog reset
// - Write-protect at trip point, power-fail at battery level
// - Missing strobe within watchdog period resets
// - Sleep holds interrupt idle, reloads watchdog, stops comparator sampling
// - Pushbutton edge wakes, then watchdog reset
// - High wake/sleep control leaves sleep
// - Supply return above battery wakes device
// - Power loss in sleep: resets per mode
// - Three input samples 33 us apart trigger
`ifndef SUPPLY_SUPERVISOR_DEFINES_VH
`define SUPPLY_SUPERVISOR_DEFINES_VH
`define CLOCK_MHZ           50
`define SAMPLE_PERIOD_US    33
`define SAMPLE_CYCLES       (`SAMPLE_PERIOD_US * `CLOCK_MHZ)
`define SAMPLE_COUNT_NEEDED 3
`define PULSE_MIN_US        200
`define PULSE_CYCLES        (`PULSE_MIN_US * `CLOCK_MHZ)
`define RESET_ACTIVE_MS     100
`define RESET_CYCLES_DEF    (`RESET_ACTIVE_MS * 1000 * `CLOCK_MHZ)
`define WATCHDOG_MS         150
`define WATCHDOG_CYCLES_DEF (`WATCHDOG_MS * 1000 * `CLOCK_MHZ)
`define SLEEP_ENTRY_US      1
`define SLEEP_ENTRY_CYCLES  (`SLEEP_ENTRY_US * `CLOCK_MHZ)
`define TIMER_WIDTH         24
`endif

// ==== verilog/sample_history.v ====
// Shift history of early-warning comparator samples
`timescale 1ns/1ps
`default_nettype none
module sample_history
(
	input  wire       clock,
	input  wire       rst,
	input  wire       take,
	input  wire       lowSample,
	input  wire       clear,
	output reg  [2:0] history
);
	// Shift in one sample per sample tick
	always @(posedge clock or posedge rst)
	begin
		if (rst)
			history <= 3'h0;
		else if (clear)
			history <= 3'h0;
		else if (take)
			history <= {history[1:0], lowSample};
	end
endmodule
`default_nettype wire

// ==== verilog/supply_supervisor_reset_sleep.v ====
// Supply supervisor: interrupt, resets, write-protect, power fail, sleep
`timescale 1ns/1ps
`include "supply_supervisor_defines.vh"
`default_nettype none
module supply_supervisor_reset_sleep
#(
	parameter [23:0] RESET_CYCLES    = `RESET_CYCLES_DEF,
	parameter [23:0] WATCHDOG_CYCLES = `WATCHDOG_CYCLES_DEF
)
(
	input  wire clock,
	input  wire rst,
	input  wire mode_select,
	input  wire inputBelowThreshold,
	input  wire supplyAboveTrip,
	input  wire supplyAboveBattery,
	input  wire pushbutton_reset_n,
	input  wire watchdog_strobe_n,
	input  wire wake_sleep_control,
	input  wire chipEnableIn_n,
	output reg  interruptOut_n,
	output reg  interruptOutEnable,
	output reg  resetOut_n,
	output reg  resetOut,
	output reg  resetOutEnable,
	output reg  chip_enable_out_n,
	output reg  power_fail_out,
	output reg  power_fail_out_n,
	output reg  sleeping
);
	localparam [1:0] IDLE   = 2'h0;
	localparam [1:0] PULSE  = 2'h1;
	localparam [1:0] QUIET  = 2'h2;
	localparam [1:0] MUTED  = 2'h3;
	// Reload values, cut to the timer widths where they are used
	localparam [31:0] SAMPLE_RELOAD = `SAMPLE_CYCLES - 1;
	localparam [31:0] PULSE_LOAD    = `PULSE_CYCLES;
	// Count one less so a wake fall exactly on the delay is accepted
	localparam [31:0] SLEEP_LOAD    = `SLEEP_ENTRY_CYCLES - 1;

	// Saturating decrement shared by all timers except the sample divider
	function [23:0] countDown;
		input [23:0] value;
		begin
			countDown = (value == 24'h000000) ? value : value - 24'h000001;
		end
	endfunction

	reg  [1:0]  intState;
	reg  [15:0] pulseTimer;
	reg  [10:0] sampleTimer;
	reg  [23:0] resetTimer;
	reg  [23:0] watchdogTimer;
	reg  [7:0]  sleepTimer;
	reg         resetActive;
	reg         strobePrev;
	reg         buttonPrev;
	reg         wakePrev;
	reg         aboveBatteryPrev;
	reg         aboveTripPrev;
	reg         inputBelowPrev;
	reg         powerValid;
	reg         tripSeen;
	wire [2:0]  history;
	wire        sampleTick;
	wire        lowConfirmed;
	wire        strobeFall;
	wire        buttonFall;
	wire        wakeFall;
	wire        inputRise;
	wire        batteryRise;
	wire        tripFall;
	wire        backed;
	wire [23:0] next_pulseTimer;
	wire [23:0] next_sleepTimer;

	// Saturated next values of the short timers
	assign next_pulseTimer = countDown({8'h00, pulseTimer});
	assign next_sleepTimer = countDown({16'h0000, sleepTimer});
	assign backed      = mode_select;
	assign sampleTick  = (sampleTimer == 11'h000);
	assign strobeFall  = strobePrev & ~watchdog_strobe_n;
	assign buttonFall  = buttonPrev & ~pushbutton_reset_n;
	assign wakeFall    = wakePrev & ~wake_sleep_control;
	assign inputRise   = inputBelowPrev & ~inputBelowThreshold;
	assign batteryRise = ~aboveBatteryPrev & supplyAboveBattery;
	assign tripFall    = aboveTripPrev & ~supplyAboveTrip;
	// Three consecutive low samples, only once the supply reached trip
	assign lowConfirmed = (history == 3'h7) & tripSeen;

	sample_history u_history
	(
		.clock     (clock),
		.rst       (rst),
		.take      (sampleTick & ~sleeping),
		.lowSample (inputBelowThreshold),
		.clear     (~inputBelowThreshold | sleeping),
		.history   (history)
	);

	// Edge detection registers
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			strobePrev       <= 1'b1;
			buttonPrev       <= 1'b1;
			wakePrev         <= 1'b0;
			aboveBatteryPrev <= 1'b0;
			aboveTripPrev    <= 1'b0;
			inputBelowPrev   <= 1'b0;
		end
		else
		begin
			strobePrev       <= watchdog_strobe_n;
			buttonPrev       <= pushbutton_reset_n;
			wakePrev         <= wake_sleep_control;
			aboveBatteryPrev <= supplyAboveBattery;
			aboveTripPrev    <= supplyAboveTrip;
			inputBelowPrev   <= inputBelowThreshold;
		end
	end

	// Sample clock divider for the comparator
	always @(posedge clock or posedge rst)
	begin
		if (rst)
			sampleTimer <= 11'h000;
		else if (sampleTick)
			sampleTimer <= SAMPLE_RELOAD[10:0];
		else
			sampleTimer <= sampleTimer - 11'h001;
	end

	// Power state: below battery clears trip gate and arms power-up
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			powerValid <= 1'b0;
			tripSeen   <= 1'b0;
		end
		else
		begin
			powerValid <= supplyAboveBattery;
			if (!supplyAboveBattery)
				tripSeen <= 1'b0;
			else if (supplyAboveTrip)
				tripSeen <= 1'b1;
		end
	end

	// Sleep control: entry after strobe delay, exits by three sources
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			sleeping   <= 1'b0;
			sleepTimer <= 8'h00;
		end
		else
		begin
			if (strobeFall)
				sleepTimer <= SLEEP_LOAD[7:0];
			else
				sleepTimer <= next_sleepTimer[7:0];
			if (sleeping && wake_sleep_control)
				sleeping <= 1'b0;
			else if (sleeping && buttonFall)
				sleeping <= 1'b0;
			else if (sleeping && batteryRise)
				sleeping <= 1'b0;
			else if (wakeFall && sleepTimer == 8'h00 && supplyAboveTrip)
				sleeping <= 1'b1;
		end
	end

	// Interrupt sequencer: pulse, quiet wait, muted after pulse
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			intState   <= IDLE;
			pulseTimer <= 16'h0000;
		end
		else if (sleeping || !supplyAboveBattery)
		begin
			intState   <= IDLE;
			pulseTimer <= 16'h0000;
		end
		else
		begin
			case (intState)
				IDLE:
				begin
					if (lowConfirmed)
					begin
						intState   <= PULSE;
						pulseTimer <= PULSE_LOAD[15:0];
					end
				end
				PULSE:
				begin
					pulseTimer <= next_pulseTimer[15:0];
					if (!inputBelowThreshold)
						intState <= IDLE;
					else if (pulseTimer == 16'h0001)
						intState <= backed ? MUTED : QUIET;
				end
				QUIET, MUTED:
				begin
					if (!inputBelowThreshold)
						intState <= IDLE;
					else if (strobeFall)
					begin
						intState   <= PULSE;
						pulseTimer <= PULSE_LOAD[15:0];
					end
				end
				default:
					intState <= IDLE;
			endcase
		end
	end

	// Reset timer and watchdog
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			resetActive   <= 1'b1;
			resetTimer    <= RESET_CYCLES;
			watchdogTimer <= WATCHDOG_CYCLES;
		end
		else if (!supplyAboveBattery)
		begin
			resetActive   <= ~backed;
			resetTimer    <= RESET_CYCLES;
			watchdogTimer <= WATCHDOG_CYCLES;
		end
		else if (batteryRise)
		begin
			resetActive <= 1'b1;
			resetTimer  <= RESET_CYCLES;
		end
		else if (!backed && !supplyAboveTrip)
		begin
			resetActive <= 1'b1;
			resetTimer  <= RESET_CYCLES;
		end
		else if (sleeping)
		begin
			resetActive   <= 1'b0;
			watchdogTimer <= WATCHDOG_CYCLES;
		end
		else if (resetActive)
		begin
			resetTimer    <= countDown(resetTimer);
			watchdogTimer <= WATCHDOG_CYCLES;
			if (backed && intState == PULSE)
				resetActive <= 1'b0;
			else if (resetTimer == 24'h000000)
				resetActive <= 1'b0;
		end
		else if (backed && inputRise && !tripFall)
		begin
			// Input recovery must end the muted wait, so it goes first
			resetActive <= 1'b1;
			resetTimer  <= RESET_CYCLES;
		end
		else if (intState == MUTED)
			watchdogTimer <= WATCHDOG_CYCLES;
		else if (strobeFall)
			watchdogTimer <= WATCHDOG_CYCLES;
		else if (watchdogTimer == 24'h000000)
		begin
			resetActive   <= 1'b1;
			resetTimer    <= RESET_CYCLES;
			watchdogTimer <= WATCHDOG_CYCLES;
		end
		else
			watchdogTimer <= countDown(watchdogTimer);
	end

	// Output drive and high-impedance control per mode
	always @(posedge clock or posedge rst)
	begin
		if (rst)
		begin
			interruptOut_n     <= 1'b1;
			interruptOutEnable <= 1'b0;
			resetOut_n         <= 1'b0;
			resetOut           <= 1'b1;
			resetOutEnable     <= 1'b0;
			chip_enable_out_n  <= 1'b1;
			power_fail_out     <= 1'b1;
			power_fail_out_n   <= 1'b0;
		end
		else
		begin
			interruptOut_n     <= ~(intState == PULSE);
			interruptOutEnable <= powerValid | backed;
			resetOut_n         <= ~resetActive;
			resetOut           <= resetActive;
			resetOutEnable     <= powerValid | backed;
			chip_enable_out_n  <= supplyAboveTrip ? chipEnableIn_n
				: 1'b1;
			power_fail_out     <= ~supplyAboveBattery;
			power_fail_out_n   <= supplyAboveBattery;
		end
	end
endmodule
`default_nettype wire

// ==== testbench/supervisor_checker_assertions.sv ====
// Port-level checks for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module supervisor_checker
(
	input wire logic clock,
	input wire logic rst,
	input wire logic mode_select,
	input wire logic inputBelowThreshold,
	input wire logic supplyAboveTrip,
	input wire logic supplyAboveBattery,
	input wire logic interruptOut_n,
	input wire logic interruptOutEnable,
	input wire logic resetOut_n,
	input wire logic resetOutEnable,
	input wire logic power_fail_out,
	input wire logic power_fail_out_n,
	input wire logic sleeping
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	int inLow;
	int lowLen;
	// Run lengths of a low input and of a low interrupt
	always @(posedge clock or posedge rst)
		if (rst)
		begin
			inLow <= 0;
			lowLen <= 0;
		end
		else
		begin
			inLow <= inputBelowThreshold ? inLow + 1 : 0;
			lowLen <= interruptOut_n ? 0 : lowLen + 1;
		end
	a_pf_pair: assert property (power_fail_out != power_fail_out_n)
		else $error("pf pair");
	a_pf_below: assert property (!supplyAboveBattery [*3] |-> power_fail_out)
		else $error("pf low");
	a_pins_float: assert property ((!mode_select && !supplyAboveBattery) [*3]
		|-> !interruptOutEnable && !resetOutEnable) else $error("float");
	a_trip_reset: assert property ((!mode_select && supplyAboveBattery
		&& !supplyAboveTrip && !inputBelowThreshold) [*3]
		|-> !resetOut_n && resetOutEnable) else $error("trip rst");
	a_backed_hold: assert property (mode_select && resetOut_n
		&& $fell(supplyAboveTrip) |=> resetOut_n) else $error("backed");
	a_warn_delay: assert property ($fell(interruptOut_n)
		&& interruptOutEnable |-> inLow >= 3290) else $error("early");
	a_pulse_min: assert property ($rose(interruptOut_n) && inputBelowThreshold
		&& supplyAboveBattery && !sleeping |-> lowLen >= 9990) else $error("short");
	a_sleep_quiet: assert property (sleeping && $past(sleeping)
		&& supplyAboveTrip |-> !$fell(interruptOut_n)) else $error("asleep");
endmodule
bind supply_supervisor_reset_sleep supervisor_checker supervisor_checker_inst (.*);
`default_nettype wire

// ==== testbench/host_model.sv ====
// Host processor model: watchdog strobes and sleep entry
`timescale 1ns/1ps
`default_nettype none
module host_model
(
	input  wire logic       clock,
	input  wire logic       kickOn,
	input  wire logic       sleepReq,
	input  wire logic [7:0] gap,
	output var  logic       watchdog_strobe_n,
	output var  logic       wake_sleep_control
);
	logic [6:0] t = 0;
	// Strobe every 100 cycles; sleep edge follows a strobe by gap
	always @(negedge clock)
	begin
		t <= (t == 7'd99) ? 7'd0 : t + 7'd1;
		watchdog_strobe_n <= !(kickOn && t == 7'd0);
		if (!sleepReq)
			wake_sleep_control <= 1'b1;
		else if (kickOn && t == gap[6:0])
			wake_sleep_control <= 1'b0;
	end
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock = 0, rst = 1, mode_select = 0, inputBelowThreshold = 0;
	logic supplyAboveTrip = 1, supplyAboveBattery = 1, chipEnableIn_n = 1;
	logic pushbutton_reset_n = 1, kickOn = 0, sleepReq = 0;
	logic [7:0] gap = 8'h32;
	logic watchdog_strobe_n, wake_sleep_control, interruptOut_n, resetOut;
	logic interruptOutEnable, resetOut_n, resetOutEnable, chip_enable_out_n;
	logic power_fail_out, power_fail_out_n, sleeping;
	int num_errors = 0, tests_run = 0, seed = 22526, n;
	logic pfQueue[$];
	logic ceQueue[$];
	wire [2:0] obs = {sleeping, resetOut_n, interruptOut_n};
	always #10 clock = ~clock;
	supply_supervisor_reset_sleep #(.RESET_CYCLES(24'hC8),
		.WATCHDOG_CYCLES(24'h190)) supply_supervisor_reset_sleep_inst (.*);
	host_model host_model_inst (.*);
	task automatic chk(input string s, input logic e, input logic v);
		tests_run++;
		if (v !== e)
		begin
			$display("wrong value %s exp %b got %b", s, e, v);
			num_errors++;
		end
	endtask
	// Reference model: power fail and write-protect one clock late
	always @(posedge clock)
		if (rst)
		begin
			pfQueue.delete();
			ceQueue.delete();
		end
		else
		begin
			if (pfQueue.size() > 0)
				chk("pf model", pfQueue.pop_front(), power_fail_out);
			if (ceQueue.size() > 0)
				chk("ce model", ceQueue.pop_front(), chip_enable_out_n);
			pfQueue.push_back(!supplyAboveBattery);
			ceQueue.push_back(!supplyAboveTrip | chipEnableIn_n);
		end
	task results;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Bounded wait for observed bit k to reach e; n holds the cycles
	task w(input int k, input logic e, input int m);
		n = 0;
		while (obs[k] !== e && n < m)
		begin
			@(negedge clock);
			n++;
		end
		chk("obs", e, obs[k]);
		if (obs[k] !== e)
			results;
	endtask
	task cyc(input int c);
		repeat (c) @(negedge clock);
	endtask
	initial
	begin
		cyc(16);
		rst = 0;
		kickOn = 1;
		chipEnableIn_n = 0;
		w(1, 1, 300);
		chk("por", 1, n >= 190);
		inputBelowThreshold = 1;
		w(0, 0, 6000);
		chk("lat", 1, n >= 3290);
		w(0, 1, 12000);
		chk("len", 1, n >= 9990);
		w(0, 0, 200);
		inputBelowThreshold = 0;
		w(0, 1, 300);
		$display("test warning done");
		chk("cef", 0, chip_enable_out_n);
		supplyAboveTrip = 0;
		w(1, 0, 20);
		chk("rsth", 1, resetOut);
		supplyAboveBattery = 0;
		cyc(4);
		chk("pf", 1, power_fail_out);
		chk("ce", 1, chip_enable_out_n);
		supplyAboveBattery = 1;
		supplyAboveTrip = 1;
		cyc(4);
		chk("pf", 0, power_fail_out);
		w(1, 1, 300);
		chk("per", 1, n >= 190);
		kickOn = 0;
		w(1, 0, 500);
		kickOn = 1;
		w(1, 1, 300);
		$display("test volatile done");
		mode_select = 1;
		supplyAboveTrip = 0;
		cyc(20);
		chk("rstb", 1, resetOut_n);
		supplyAboveTrip = 1;
		inputBelowThreshold = 1;
		w(0, 0, 6000);
		w(0, 1, 12000);
		chk("blen", 1, n >= 9990);
		kickOn = 0;
		cyc(600);
		chk("mute", 1, resetOut_n);
		inputBelowThreshold = 0;
		w(1, 0, 20);
		kickOn = 1;
		w(1, 1, 300);
		$display("test backed done");
		gap = 8'(50 + ($random(seed) & 31));
		sleepReq = 1;
		w(2, 1, 300);
		kickOn = 0;
		inputBelowThreshold = 1;
		cyc(4000);
		chk("slp", 1, interruptOut_n);
		inputBelowThreshold = 0;
		pushbutton_reset_n = 0;
		w(2, 0, 20);
		pushbutton_reset_n = 1;
		w(1, 0, 500);
		kickOn = 1;
		sleepReq = 0;
		w(1, 1, 300);
		sleepReq = 1;
		w(2, 1, 300);
		supplyAboveTrip = 0;
		supplyAboveBattery = 0;
		cyc(4);
		chk("slpdn", 1, resetOut_n);
		supplyAboveBattery = 1;
		supplyAboveTrip = 1;
		w(2, 0, 20);
		sleepReq = 0;
		cyc(2);
		sleepReq = 1;
		w(2, 1, 300);
		sleepReq = 0;
		w(2, 0, 20);
		$display("test sleep done");
		results;
	end
endmodule
`default_nettype wire
